// [hdl/txs_pkg.sv]
`default_nettype none
package txs_pkg;

  // Serial command bytes.
  localparam logic [7:0] CMD_WRITE    = 8'h01;
  localparam logic [7:0] CMD_READ     = 8'h02;
  localparam logic [7:0] CMD_READ_END = 8'h00;

  // Device register file.
  localparam int         REG_COUNT     = 32;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] GEN_CFG_ADDR  = 8'h01;
  localparam int         BOOST_BIT     = 6;
  localparam logic [7:0] CLK_CTRL_ADDR = 8'h02;
  localparam int         DIV_LSB       = 0;
  localparam int         DIV_W         = 3;
  localparam int         CLK_SRC_BIT   = 3;
  localparam int         GP2_SEL_LSB   = 4;
  localparam int         GP2_SEL_W     = 2;

  // Clock output source and shared pin selections.
  localparam logic       CLK_SRC_DIV   = 1'b0;
  localparam logic [1:0] GP2_LOCK      = 2'h0;
  localparam logic [1:0] GP2_LOW       = 2'h1;
  localparam logic [1:0] GP2_HIGH      = 2'h2;
  localparam logic [1:0] GP2_CLOCK     = 2'h3;

  // Divide codes: 0 passes the clock to the clock output pin but divides by 16 on the shared pin, 1..4 divide by 2..16.
  localparam logic [2:0] DIV_BY_1      = 3'h0;
  localparam logic [2:0] DIV_BY_16     = 3'h4;

  // Host command port offsets and fields.
  localparam logic [2:0] HOST_CTRL     = 3'h0;
  localparam logic [2:0] HOST_TX       = 3'h1;
  localparam logic [2:0] HOST_RX       = 3'h2;
  localparam logic [2:0] HOST_STATUS   = 3'h3;
  localparam int         CTRL_SEL_BIT  = 0;
  localparam int         CTRL_FREQ_LSB = 1;
  localparam logic [7:0] HOST_RESET    = 8'h00;

  // Serial clock half period.
  localparam int         CORE_CLK_NS   = 10;
  localparam int         SCLK_HALF_NS  = 80;
  localparam int         SCLK_HALF_CYC = SCLK_HALF_NS / CORE_CLK_NS;

endpackage
`default_nettype wire

// [hdl/txs_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface txs_link_if;
  logic select_n_pin;
  logic serial_clock_pin;
  logic serial_in_pin;
  logic serial_out_gp2_pin;
  logic clock_out_pin;
  logic clock_out_drive_boost;
  logic freq_select_pin_hi;
  logic freq_select_pin_mid;
  logic freq_select_pin_lo;

  modport dev (
    input  select_n_pin,
    input  serial_clock_pin,
    input  serial_in_pin,
    input  freq_select_pin_hi,
    input  freq_select_pin_mid,
    input  freq_select_pin_lo,
    output serial_out_gp2_pin,
    output clock_out_pin,
    output clock_out_drive_boost
  );

  modport host (
    output select_n_pin,
    output serial_clock_pin,
    output serial_in_pin,
    output freq_select_pin_hi,
    output freq_select_pin_mid,
    output freq_select_pin_lo,
    input  serial_out_gp2_pin,
    input  clock_out_pin,
    input  clock_out_drive_boost
  );
endinterface
`default_nettype wire

// [hdl/txs_dev.sv]
`timescale 1ns/1ns
`default_nettype none
module txs_dev
  import txs_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  txs_link_if.dev         link,
  input  wire logic       i_lock,
  output logic            o_serial_mode,
  output logic [7:0]      o_general_config
);

  typedef enum logic [2:0] {
    TXS_CMD,
    TXS_WR_ADDR,
    TXS_WR_DATA,
    TXS_RD_ADDR,
    TXS_SKIP
  } txs_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Functions.

  // Register read with unmapped addresses answering zero.
  function automatic logic [7:0] reg_rd(
    input logic [7:0] regs [REG_COUNT],
    input logic [7:0] addr
  );
    logic [7:0] val;
    val = 8'h00;
    if (int'(addr) < REG_COUNT) begin
      val = regs[addr[4:0]];
    end
    return val;
  endfunction

  // Picks the divider bit for a divide code; codes above 4 act as 4 (divide by 16).
  function automatic logic div_bit(
    input logic [3:0] cnt,
    input logic [2:0] code
  );
    logic b;
    b = cnt[3];
    unique case (code)
      3'h1:    b = cnt[0];
      3'h2:    b = cnt[1];
      3'h3:    b = cnt[2];
      default: b = cnt[3];
    endcase
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  localparam int SYNC_W = 7;

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic              sclk_d_r;
  logic              cs_n_s;
  logic              sclk_s;
  logic              sdi_s;
  logic              lock_s;
  logic              serial_s;
  logic              sclk_rise;
  logic              sclk_fall;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r  <= 7'h01;
      sync2_r  <= 7'h01;
      sclk_d_r <= 1'b0;
    end else begin
      sync1_r  <= {i_lock, link.freq_select_pin_hi,
                   link.freq_select_pin_mid, link.freq_select_pin_lo,
                   link.serial_in_pin, link.serial_clock_pin,
                   link.select_n_pin};
      sync2_r  <= sync1_r;
      sclk_d_r <= sync2_r[1];
    end
  end

  assign cs_n_s    = sync2_r[0];
  assign sclk_s    = sync2_r[1];
  assign sdi_s     = sync2_r[2];
  assign lock_s    = sync2_r[6];
  assign serial_s  = (sync2_r[5:3] == 3'h0);
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  //////////////////////////////////////////////////////////////////////////
  // Byte framing.

  logic       active;
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_r;
  logic [7:0] rx_byte;
  logic       byte_done;

  assign active    = serial_s & ~cs_n_s;
  assign rx_byte   = {rx_r, sdi_s};
  assign byte_done = active & sclk_rise & (bit_cnt_r == 3'h7);

  // Bytes run back to back for as long as select stays low.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_r <= 3'h0;
      rx_r      <= 7'h00;
    end else if (!active) begin
      bit_cnt_r <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_r      <= rx_byte[6:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command decoding.

  txs_state_t state_r;
  logic [7:0] ptr_r;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= TXS_CMD;
    end else if (!active) begin
      state_r <= TXS_CMD;
    end else if (byte_done) begin
      unique case (state_r)
        TXS_CMD: begin
          if (rx_byte == CMD_WRITE) begin
            state_r <= TXS_WR_ADDR;
          end else if (rx_byte == CMD_READ) begin
            state_r <= TXS_RD_ADDR;
          end else begin
            state_r <= TXS_SKIP;
          end
        end
        TXS_WR_ADDR: state_r <= TXS_WR_DATA;
        TXS_WR_DATA: state_r <= TXS_WR_DATA;
        TXS_RD_ADDR: state_r <= TXS_RD_ADDR;
        TXS_SKIP:    state_r <= TXS_SKIP;
      endcase
    end
  end

  // Write pointer: loaded with the start address, then steps per byte.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr_r <= 8'h00;
    end else if (byte_done && state_r == TXS_WR_ADDR) begin
      ptr_r <= rx_byte;
    end else if (byte_done && state_r == TXS_WR_DATA) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0] regs_r [REG_COUNT];
  logic [7:0] cfg;
  logic [7:0] ctl;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (byte_done && state_r == TXS_WR_DATA &&
                 int'(ptr_r) < REG_COUNT) begin
      regs_r[ptr_r[4:0]] <= rx_byte;
    end
  end

  assign cfg = reg_rd(regs_r, GEN_CFG_ADDR);
  assign ctl = reg_rd(regs_r, CLK_CTRL_ADDR);

  //////////////////////////////////////////////////////////////////////////
  // Read data shifter.

  logic [7:0] tx_r;

  // A byte loaded at the end of input byte n goes out during byte n+1,
  // so the command and first address bytes answer with filler.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_r <= 8'h00;
    end else if (!active) begin
      tx_r <= 8'h00;
    end else if (byte_done) begin
      if (state_r == TXS_RD_ADDR) begin
        tx_r <= reg_rd(regs_r, rx_byte);
      end else begin
        tx_r <= 8'h00;
      end
    end else if (sclk_fall && bit_cnt_r != 3'h0) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock divider and output pins.

  logic [3:0] div_cnt_r;
  logic [3:0] div_cnt_nxt;
  logic       div_clk_r;
  logic       clk_bypass_r;
  logic       clk_out_r;
  logic       gp2_r;
  logic       boost_r;
  logic       gp2_sel_val;
  logic [2:0] div_code;

  assign div_cnt_nxt = div_cnt_r + 4'h1;
  assign div_code    = ctl[DIV_LSB +: DIV_W];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_r <= 4'h0;
      div_clk_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      div_clk_r <= div_bit(div_cnt_nxt, div_code);
    end
  end

  always_comb begin
    unique case (ctl[GP2_SEL_LSB +: GP2_SEL_W])
      GP2_LOCK:  gp2_sel_val = lock_s;
      GP2_LOW:   gp2_sel_val = 1'b0;
      GP2_HIGH:  gp2_sel_val = 1'b1;
      GP2_CLOCK: gp2_sel_val = div_clk_r;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_out_r    <= 1'b0;
      clk_bypass_r <= 1'b0;
      boost_r      <= 1'b0;
    end else if (!serial_s) begin
      clk_out_r    <= lock_s;
      clk_bypass_r <= 1'b0;
      boost_r      <= 1'b0;
    end else begin
      if (ctl[CLK_SRC_BIT] == CLK_SRC_DIV) begin
        clk_out_r <= div_clk_r;
      end else begin
        clk_out_r <= lock_s;
      end
      clk_bypass_r <= (ctl[CLK_SRC_BIT] == CLK_SRC_DIV) &&
                      (div_code == DIV_BY_1);
      boost_r      <= cfg[BOOST_BIT];
    end
  end

  // The shared pin is held low in manual mode, where it is not an output.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gp2_r <= 1'b0;
    end else if (!serial_s) begin
      gp2_r <= 1'b0;
    end else if (!cs_n_s) begin
      gp2_r <= tx_r[7];
    end else begin
      gp2_r <= gp2_sel_val;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_serial_mode    <= 1'b0;
      o_general_config <= 8'h00;
    end else begin
      o_serial_mode    <= serial_s;
      o_general_config <= cfg;
    end
  end

  // Divide by one passes the clock itself; switching into or out of it
  // may leave one short pulse on the pin.
  assign link.clock_out_pin         = clk_bypass_r ? i_core_clk : clk_out_r;
  assign link.serial_out_gp2_pin    = gp2_r;
  assign link.clock_out_drive_boost = boost_r;

endmodule
`default_nettype wire

// [hdl/txs_host.sv]
`timescale 1ns/1ns
`default_nettype none
module txs_host
  import txs_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  txs_link_if.host        link,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata
);

  typedef enum logic [1:0] {
    TXS_H_IDLE,
    TXS_H_LOW,
    TXS_H_HIGH
  } txs_host_state_t;

  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);

  logic [7:0]      ctrl_r;
  logic [7:0]      rx_data_r;
  logic [7:0]      tx_r;
  logic [7:0]      rx_r;
  logic [2:0]      bits_r;
  logic [3:0]      half_r;
  logic            sclk_r;
  logic            sdi_r;
  logic [1:0]      sync1_r;
  logic [1:0]      sync2_r;
  txs_host_state_t state_r;
  logic            busy;

  assign busy = (state_r != TXS_H_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: shared output pin and clock output pin.

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= {link.clock_out_pin, link.serial_out_gp2_pin};
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command port registers.

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= HOST_RESET;
    end else if (i_wr && i_addr == HOST_CTRL) begin
      ctrl_r <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        HOST_CTRL:   o_rdata <= ctrl_r;
        HOST_RX:     o_rdata <= rx_data_r;
        HOST_STATUS: o_rdata <= {5'h00, sync2_r, busy};
        default:     o_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte shifter, serial clock idles low, data changes on falling edges.

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r   <= TXS_H_IDLE;
      tx_r      <= 8'h00;
      rx_r      <= 8'h00;
      rx_data_r <= 8'h00;
      bits_r    <= 3'h0;
      half_r    <= 4'h0;
      sclk_r    <= 1'b0;
      sdi_r     <= 1'b0;
    end else begin
      unique case (state_r)
        TXS_H_IDLE: begin
          if (i_wr && i_addr == HOST_TX) begin
            tx_r    <= i_wdata;
            sdi_r   <= i_wdata[7];
            bits_r  <= 3'h0;
            half_r  <= HALF_LAST;
            state_r <= TXS_H_LOW;
          end
        end
        TXS_H_LOW: begin
          if (half_r == 4'h0) begin
            sclk_r  <= 1'b1;
            rx_r    <= {rx_r[6:0], sync2_r[0]};
            half_r  <= HALF_LAST;
            state_r <= TXS_H_HIGH;
          end else begin
            half_r <= half_r - 4'h1;
          end
        end
        TXS_H_HIGH: begin
          if (half_r == 4'h0) begin
            sclk_r <= 1'b0;
            if (bits_r == 3'h7) begin
              rx_data_r <= rx_r;
              state_r   <= TXS_H_IDLE;
            end else begin
              bits_r  <= bits_r + 3'h1;
              tx_r    <= {tx_r[6:0], 1'b0};
              sdi_r   <= tx_r[6];
              half_r  <= HALF_LAST;
              state_r <= TXS_H_LOW;
            end
          end else begin
            half_r <= half_r - 4'h1;
          end
        end
      endcase
    end
  end

  assign link.select_n_pin        = ~ctrl_r[CTRL_SEL_BIT];
  assign link.serial_clock_pin    = sclk_r;
  assign link.serial_in_pin       = sdi_r;
  assign link.freq_select_pin_lo  = ctrl_r[CTRL_FREQ_LSB];
  assign link.freq_select_pin_mid = ctrl_r[CTRL_FREQ_LSB + 1];
  assign link.freq_select_pin_hi  = ctrl_r[CTRL_FREQ_LSB + 2];

endmodule
`default_nettype wire

// [bench/txs_props.sv]
`timescale 1ns/1ns
`default_nettype none
module txs_props (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic select_n_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic serial_out_gp2_pin,
  input wire logic clock_out_pin,
  input wire logic clock_out_drive_boost,
  input wire logic freq_select_pin_hi,
  input wire logic freq_select_pin_mid,
  input wire logic freq_select_pin_lo
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  logic freq_any;
  assign freq_any = freq_select_pin_hi | freq_select_pin_mid
                  | freq_select_pin_lo;

  ////////////////////////////////////////////////////////////////////////////
  property p_sclk_sel;
    serial_clock_pin |-> !select_n_pin;
  endproperty
  a_sclk_sel: assert property (p_sclk_sel)
    else $error("serial clock high while deselected");

  property p_sclk_half;
    $changed(serial_clock_pin) |=> $stable(serial_clock_pin) [*7];
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock half period too short");

  property p_sdi_hold;
    serial_clock_pin && $past(serial_clock_pin) |-> $stable(serial_in_pin);
  endproperty
  a_sdi_hold: assert property (p_sdi_hold)
    else $error("serial input moved while clock high");

  property p_sel_freq;
    $fell(select_n_pin) |-> !freq_any;
  endproperty
  a_sel_freq: assert property (p_sel_freq)
    else $error("select taken outside serial mode");

  property p_freq_hold;
    !select_n_pin && $past(!select_n_pin) |-> $stable(freq_any);
  endproperty
  a_freq_hold: assert property (p_freq_hold)
    else $error("frequency pins moved while selected");

  property p_boost_manual;
    freq_any [*6] |-> !clock_out_drive_boost;
  endproperty
  a_boost_manual: assert property (p_boost_manual)
    else $error("drive boost active in manual mode");

  sequence s_sel_quiet;
    (!select_n_pin && $stable(serial_clock_pin) && $stable(select_n_pin));
  endsequence
  property p_sdo_quiet;
    s_sel_quiet [*7] |-> $stable(serial_out_gp2_pin);
  endproperty
  a_sdo_quiet: assert property (p_sdo_quiet)
    else $error("read data moved without a serial clock edge");

  property p_sel_rise;
    $rose(select_n_pin) |-> !serial_clock_pin ##1 !serial_clock_pin;
  endproperty
  a_sel_rise: assert property (p_sel_rise)
    else $error("select released with serial clock high");

  c_select: cover property ($fell(select_n_pin));
  c_boost: cover property ($rose(clock_out_drive_boost));
  c_manual: cover property ($rose(freq_any));
endmodule
`default_nettype wire

// [bench/test_transmitter_spi_regs_gpo.sv]
`timescale 1ns/1ns
`default_nettype none
module test_transmitter_spi_regs_gpo import txs_pkg::*;;
  logic       clk;
  logic       rst;
  logic       lock;
  logic       wr;
  logic       rd;
  logic       cnt_en;
  logic       smode;
  logic       gexp;
  logic [1:0] sel;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rx;
  logic [7:0] cfg;
  logic [7:0] gcfg;
  logic [7:0] rd_in  [6];
  logic [7:0] rd_exp [6];
  int         n_fail;
  int         checks_done;
  int         edges;
  int         k;

  txs_link_if link ();

  txs_dev u_txs_dev (.i_core_clk(clk), .i_rst(rst), .link(link),
    .i_lock(lock), .o_serial_mode(smode), .o_general_config(gcfg));
  txs_host u_txs_host (.i_core_clk(clk), .i_rst(rst), .link(link),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
  txs_props u_txs_props (.i_core_clk(clk), .i_rst(rst),
    .select_n_pin(link.select_n_pin),
    .serial_clock_pin(link.serial_clock_pin),
    .serial_in_pin(link.serial_in_pin),
    .serial_out_gp2_pin(link.serial_out_gp2_pin),
    .clock_out_pin(link.clock_out_pin),
    .clock_out_drive_boost(link.clock_out_drive_boost),
    .freq_select_pin_hi(link.freq_select_pin_hi),
    .freq_select_pin_mid(link.freq_select_pin_mid),
    .freq_select_pin_lo(link.freq_select_pin_lo));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  always @(posedge link.clock_out_pin) begin
    if (cnt_en) edges = edges + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t pin %b expected %b", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rx = rdata;
  endtask

  // Sends one byte and leaves the byte clocked back in rx.
  task automatic spi_byte(input logic [7:0] b);
    int i;
    bus_wr(HOST_TX, b);
    repeat (2) @(posedge clk);
    for (i = 0; i < 100; i++) begin
      bus_rd(HOST_STATUS);
      if (rx[0] === 1'b0) break;
    end
    if (i == 100) begin
      n_fail++;
      $display("[ERR] %0t host stays busy", $time);
      stop_test();
    end
    bus_rd(HOST_RX);
  endtask

  task automatic reg_write(input logic [7:0] c1, input logic [7:0] c2);
    bus_wr(HOST_CTRL, 8'h01);
    spi_byte(CMD_WRITE);
    spi_byte(GEN_CFG_ADDR);
    spi_byte(c1);
    spi_byte(c2);
    bus_wr(HOST_CTRL, 8'h00);
    repeat (20) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    lock = 1'b1;
    cnt_en = 1'b0;
    n_fail = 0;
    checks_done = 0;
    edges = 0;
    rd_in = '{CMD_READ, CLK_CTRL_ADDR, GEN_CFG_ADDR, 8'h28, GEN_CFG_ADDR,
              CMD_READ_END};
    rd_exp = '{8'h00, 8'h00, 8'h08, 8'h40, 8'h00, 8'h40};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk1(link.select_n_pin, 1'b1);
    chk1(smode, 1'b1);
    chk8(gcfg, REG_RESET);
    bus_rd(HOST_CTRL);
    chk8(rx, HOST_RESET);
    bus_rd(3'h7);
    chk8(rx, 8'h00);
    $display("reset test done");

    for (k = 0; k < 5; k++) begin
      cfg = k[0] ? 8'h00 : 8'h40;
      sel = (k % 3 == 0) ? GP2_LOW : (k % 3 == 1) ? GP2_HIGH : GP2_LOCK;
      gexp = (k % 3 != 0);
      reg_write(cfg, {2'b00, sel, CLK_SRC_DIV, 3'(k)});
      chk8(gcfg, cfg);
      chk1(link.clock_out_drive_boost, cfg[BOOST_BIT]);
      chk1(link.serial_out_gp2_pin, gexp);
      @(negedge clk);
      edges = 0;
      cnt_en = 1'b1;
      repeat (64) @(negedge clk);
      cnt_en = 1'b0;
      chk8(8'(edges), 8'(64 >> k));
    end
    // Shared pin shows the divided clock: half of 64 cycles are high.
    reg_write(8'h00, {2'b00, GP2_CLOCK, CLK_SRC_DIV, DIV_BY_16});
    @(negedge clk);
    edges = 0;
    repeat (64) begin
      @(negedge clk);
      if (link.serial_out_gp2_pin === 1'b1) edges = edges + 1;
    end
    chk8(8'(edges), 8'h20);
    $display("write and divider test done");

    reg_write(8'h40, 8'h08);
    for (k = 0; k < 2; k++) begin
      lock <= k[0];
      repeat (6) @(posedge clk);
      chk1(link.clock_out_pin, k[0]);
    end
    $display("clock source test done");

    bus_wr(HOST_CTRL, 8'h01);
    @(negedge clk);
    chk1(link.select_n_pin, 1'b0);
    for (k = 0; k < 6; k++) begin
      spi_byte(rd_in[k]);
      chk8(rx, rd_exp[k]);
    end
    bus_wr(HOST_CTRL, 8'h00);
    $display("read test done");

    // An unknown command byte makes the rest of the frame ignored.
    repeat (10) @(posedge clk);
    bus_wr(HOST_CTRL, 8'h01);
    spi_byte(8'h03);
    spi_byte(GEN_CFG_ADDR);
    spi_byte(8'h00);
    bus_wr(HOST_CTRL, 8'h00);
    repeat (20) @(posedge clk);
    chk8(gcfg, 8'h40);
    $display("unknown command test done");

    bus_wr(HOST_CTRL, 8'h02);
    repeat (10) @(posedge clk);
    chk1(smode, 1'b0);
    chk1(link.clock_out_drive_boost, 1'b0);
    chk1(link.serial_out_gp2_pin, 1'b0);
    for (k = 0; k < 2; k++) begin
      lock <= k[0];
      repeat (6) @(posedge clk);
      chk1(link.clock_out_pin, k[0]);
    end
    bus_wr(HOST_CTRL, 8'h00);
    repeat (10) @(posedge clk);
    chk1(smode, 1'b1);
    $display("manual mode test done");
    stop_test();
  end
endmodule
`default_nettype wire
